// File: common/iosf_pkg.sv
package iosf_pkg;

  // Geometry
  localparam int NUM_LINES = 13;
  localparam int NUM_AIN   = 6;
  localparam int FUNC_W    = 4;
  localparam int ADDR_W    = 8;
  localparam int DATA_W    = 16;
  localparam int ADC_W     = 10;

  // Pin function codes
  localparam logic [3:0] FN_DIN_QUIET = 4'h0;
  localparam logic [3:0] FN_ALT       = 4'h1;
  localparam logic [3:0] FN_ANALOG    = 4'h2;
  localparam logic [3:0] FN_DIN_MON   = 4'h3;
  localparam logic [3:0] FN_DOUT_LOW  = 4'h4;
  localparam logic [3:0] FN_DOUT_HIGH = 4'h5;
  localparam logic [3:0] FN_ALT_FIRST = 4'h6;
  localparam logic [3:0] FN_ALT_LAST  = 4'h9;

  // Register offsets
  localparam logic [7:0] ADDR_LINE_BASE = 8'h00;
  localparam logic [7:0] ADDR_PULLUP    = 8'h10;
  localparam logic [7:0] ADDR_CTRL      = 8'h11;
  localparam logic [7:0] ADDR_STATUS    = 8'h12;
  localparam logic [7:0] ADDR_DMASK     = 8'h13;
  localparam logic [7:0] ADDR_AMASK     = 8'h14;
  localparam logic [7:0] ADDR_DLEVEL    = 8'h15;

  // Field positions
  localparam int CTRL_GO_BIT   = 0;
  localparam int CTRL_TEXT_BIT = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;

  // Reset values and pin capabilities
  localparam logic [3:0]  LINE_CFG_RST = 4'h0;
  localparam logic [12:0] DEF_ALT_LINES = 13'h0021;
  localparam logic [12:0] ANALOG_LINES = 13'h003F;
  localparam logic [12:0] PWM_LINES    = 13'h0C00;
  localparam logic [12:0] ALT_LINES    = 13'h17E1;

  // Record layout
  localparam logic [7:0] SAMPLE_SETS  = 8'h01;
  localparam logic [3:0] FLD_COUNT    = 4'h0;
  localparam logic [3:0] FLD_DMASK    = 4'h1;
  localparam logic [3:0] FLD_AMASK    = 4'h2;
  localparam logic [3:0] FLD_DSTATE   = 4'h3;
  localparam logic [3:0] FLD_AIN_BASE = 4'h4;
  localparam logic [3:0] FLD_LAST     = 4'h9;

  // Text characters
  localparam logic [7:0] CH_ZERO  = 8'h30;
  localparam logic [7:0] CH_X     = 8'h78;
  localparam logic [7:0] CH_CR    = 8'h0D;
  localparam logic [7:0] CH_A_OFS = 8'h37;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_PICK, SEQ_EMIT} iosf_seq_e;

endpackage

// File: core/iosf_sync.sv
module iosf_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Raw and synchronised levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // Two stages; only the second stage is read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule

// File: core/iosf_emit.sv
module iosf_emit
  import iosf_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Field request
  input  wire logic        start,
  input  wire logic [15:0] value,
  input  wire logic        two_bytes,
  input  wire logic        text_mode,
  output logic             done,
  // Byte stream
  output logic [7:0]       out_data,
  output logic             out_valid,
  input  wire logic        out_ready
);

  logic [15:0] val_q;
  logic        two_q;
  logic        text_q;
  logic [2:0]  idx_q;
  logic [7:0]  data_q;
  logic        valid_q;
  logic [2:0]  last_idx;

  // Hex digit to character
  function automatic logic [7:0] hex_char(input logic [3:0] n);
    return (n < 4'hA) ? CH_ZERO + {4'h0, n} : CH_A_OFS + {4'h0, n};
  endfunction

  // Character or byte at a position of the field
  function automatic logic [7:0] char_at(input logic [2:0] i, input logic [15:0] v,
                                         input logic two, input logic txt);
    logic [2:0] nib;
    nib = 3'h0;
    if (!txt) return (two && i == 3'h0) ? v[15:8] : v[7:0];
    if (i == 3'h0) return CH_ZERO;
    if (i == 3'h1) return CH_X;
    if (i == (two ? 3'h6 : 3'h4)) return CH_CR;
    nib = (two ? 3'h5 : 3'h3) - i;
    return hex_char(v[{nib[1:0], 2'h0} +: 4]);
  endfunction

  assign last_idx = text_q ? (two_q ? 3'h6 : 3'h4) : (two_q ? 3'h1 : 3'h0);
  assign done     = valid_q && out_ready && (idx_q == last_idx);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      val_q   <= 16'h0000;
      two_q   <= 1'b0;
      text_q  <= 1'b0;
      idx_q   <= 3'h0;
      data_q  <= 8'h00;
      valid_q <= 1'b0;
    end else if (start && !valid_q) begin
      val_q   <= value;
      two_q   <= two_bytes;
      text_q  <= text_mode;
      idx_q   <= 3'h0;
      data_q  <= char_at(3'h0, value, two_bytes, text_mode);
      valid_q <= 1'b1;
    end else if (valid_q && out_ready) begin
      if (idx_q == last_idx) begin
        valid_q <= 1'b0;
      end else begin
        idx_q  <= idx_q + 3'h1;
        data_q <= char_at(idx_q + 3'h1, val_q, two_q, text_q);
      end
    end
  end

  assign out_data  = data_q;
  assign out_valid = valid_q;

endmodule

// File: core/iosf_formatter.sv
module iosf_formatter
  import iosf_pkg::*;
#(
  parameter logic [12:0] ALT_MASK = ALT_LINES
) (
  // Clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     reset_n,
  // Register port
  input  wire logic [ADDR_W-1:0]        reg_addr,
  input  wire logic [DATA_W-1:0]        reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic      [DATA_W-1:0]        reg_rdata,
  // Digital lines
  input  wire logic [NUM_LINES-1:0]     dio_in,
  output logic      [NUM_LINES-1:0]     dio_out,
  output logic      [NUM_LINES-1:0]     dio_oe,
  output logic      [NUM_LINES-1:0]     pullup_en,
  // Pin function selects
  output logic      [NUM_LINES-1:0]     alt_sel,
  output logic      [NUM_LINES-1:0]     pwm_sel,
  output logic      [NUM_AIN-1:0]       analog_sel,
  // Converter results
  input  wire logic [NUM_AIN*ADC_W-1:0] adc_data,
  // Record stream
  output logic      [7:0]               rec_data,
  output logic                          rec_valid,
  input  wire logic                     rec_ready,
  output logic                          rec_busy
);

  // Reset release
  logic rst_n;

  // Configuration state
  logic [FUNC_W-1:0]    func_q [NUM_LINES];
  logic [NUM_LINES-1:0] pullup_q;
  logic                 text_q;
  logic                 done_q;
  logic [DATA_W-1:0]    rdata_q;

  // Pin drive registers
  logic [NUM_LINES-1:0] out_d;
  logic [NUM_LINES-1:0] out_q;
  logic [NUM_LINES-1:0] oe_d;
  logic [NUM_LINES-1:0] oe_q;
  logic [NUM_LINES-1:0] pu_d;
  logic [NUM_LINES-1:0] pu_q;
  logic [NUM_LINES-1:0] alt_d;
  logic [NUM_LINES-1:0] alt_q;
  logic [NUM_LINES-1:0] pwm_d;
  logic [NUM_LINES-1:0] pwm_q;

  // Live masks and line levels
  logic [NUM_LINES-1:0] dmask_d;
  logic [NUM_AIN-1:0]   amask_d;
  logic [NUM_LINES-1:0] dio_s;

  // Snapshot of one sample
  logic [NUM_LINES-1:0] dmask_q;
  logic [NUM_AIN-1:0]   amask_q;
  logic [NUM_LINES-1:0] dstate_q;
  logic [ADC_W-1:0]     ain_q [NUM_AIN];

  // Sequencer
  iosf_seq_e            seq_q;
  logic [3:0]           fld_q;
  logic                 go;
  logic                 fld_present;
  logic [15:0]          fld_value;
  logic                 fld_two;
  logic                 emit_start;
  logic                 emit_done;
  logic                 clr_done;
  logic                 rec_end;

  // Reset released through two stages; assertion stays asynchronous
  iosf_sync #(.WIDTH(1)) u_rst_sync (
    .clk      (sys_clk),
    .rst_n    (reset_n),
    .async_in (1'b1),
    .sync_out (rst_n)
  );

  // Pins come from outside the clock domain
  iosf_sync #(.WIDTH(NUM_LINES)) u_dio_sync (
    .clk      (sys_clk),
    .rst_n    (rst_n),
    .async_in (dio_in),
    .sync_out (dio_s)
  );

  // Whether a code may be taken by a given line
  function automatic logic code_ok(input int line, input logic [FUNC_W-1:0] code);
    logic alt;
    alt = (code == FN_ALT) || (code >= FN_ALT_FIRST && code <= FN_ALT_LAST);
    if (alt) return ALT_MASK[line];
    if (code == FN_ANALOG) return ANALOG_LINES[line] || PWM_LINES[line];
    return code <= FN_DOUT_HIGH;
  endfunction

  // Digital input functions, used to gate the pull-up
  function automatic logic is_din(input logic [FUNC_W-1:0] code);
    return (code == FN_DIN_QUIET) || (code == FN_DIN_MON);
  endfunction

  // Line settings, one register per line
  for (genvar i = 0; i < NUM_LINES; i++) begin : g_line
    localparam logic [ADDR_W-1:0] LINE_ADDR = ADDR_LINE_BASE + ADDR_W'(i);
    localparam logic [FUNC_W-1:0] LINE_RST  = DEF_ALT_LINES[i] ? FN_ALT : LINE_CFG_RST;

    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        func_q[i] <= LINE_RST;
      end else if (reg_wr && reg_addr == LINE_ADDR && code_ok(i, reg_wdata[FUNC_W-1:0])) begin
        func_q[i] <= reg_wdata[FUNC_W-1:0];
      end
    end

    always_comb begin
      out_d[i] = (func_q[i] == FN_DOUT_HIGH);
      oe_d[i]  = (func_q[i] == FN_DOUT_LOW) || (func_q[i] == FN_DOUT_HIGH);
      alt_d[i] = (func_q[i] == FN_ALT) || (func_q[i] >= FN_ALT_FIRST);
      pwm_d[i] = PWM_LINES[i] && (func_q[i] == FN_ANALOG);
      pu_d[i]  = pullup_q[i] && is_din(func_q[i]);
      dmask_d[i] = (func_q[i] == FN_DIN_MON) || oe_d[i];
    end
  end

  for (genvar c = 0; c < NUM_AIN; c++) begin : g_ain
    assign amask_d[c] = ANALOG_LINES[c] && (func_q[c] == FN_ANALOG);
  end

  // Pin drives registered so the pads see clean levels
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_q <= '0;
      oe_q  <= '0;
      pu_q  <= '0;
      alt_q <= '0;
      pwm_q <= '0;
    end else begin
      out_q <= out_d;
      oe_q  <= oe_d;
      pu_q  <= pu_d;
      alt_q <= alt_d;
      pwm_q <= pwm_d;
    end
  end

  assign dio_out    = out_q;
  assign dio_oe     = oe_q;
  assign pullup_en  = pu_q;
  assign alt_sel    = alt_q;
  assign pwm_sel    = pwm_q;
  assign analog_sel = amask_d;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pullup_q <= '0;
    end else if (reg_wr && reg_addr == ADDR_PULLUP) begin
      pullup_q <= reg_wdata[NUM_LINES-1:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      text_q <= 1'b0;
    end else if (reg_wr && reg_addr == ADDR_CTRL) begin
      text_q <= reg_wdata[CTRL_TEXT_BIT];
    end
  end

  // Go is a strobe; a request while busy is dropped
  assign go       = reg_wr && reg_addr == ADDR_CTRL && reg_wdata[CTRL_GO_BIT] && seq_q == SEQ_IDLE;
  assign clr_done = reg_wr && reg_addr == ADDR_STATUS && reg_wdata[STAT_DONE_BIT];

  // Done flag; a record end beats a clear in the same cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      done_q <= 1'b0;
    end else if (rec_end) begin
      done_q <= 1'b1;
    end else if (clr_done) begin
      done_q <= 1'b0;
    end
  end

  // Snapshot taken at go, so the record is one coherent sample
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dmask_q  <= '0;
      amask_q  <= '0;
      dstate_q <= '0;
    end else if (go) begin
      dmask_q  <= dmask_d;
      amask_q  <= amask_d;
      dstate_q <= dio_s & dmask_d;
    end
  end

  // Converter results, one register per channel
  for (genvar c = 0; c < NUM_AIN; c++) begin : g_snap
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        ain_q[c] <= '0;
      end else if (go) begin
        ain_q[c] <= adc_data[c*ADC_W +: ADC_W];
      end
    end
  end

  // Current field: presence, value and size
  always_comb begin
    fld_present = 1'b1;
    fld_two     = 1'b1;
    fld_value   = 16'h0000;
    case (fld_q)
      FLD_COUNT: begin
        fld_two   = 1'b0;
        fld_value = {8'h00, SAMPLE_SETS};
      end
      FLD_DMASK: begin
        fld_value = 16'(dmask_q);
      end
      FLD_AMASK: begin
        fld_two   = 1'b0;
        fld_value = 16'(amask_q);
      end
      // state word when any line on
      FLD_DSTATE: begin
        fld_present = |dmask_q;
        fld_value   = 16'(dstate_q);
      end
      default: begin
        fld_present = amask_q[3'(fld_q - FLD_AIN_BASE)];
        fld_value   = 16'(ain_q[3'(fld_q - FLD_AIN_BASE)]);
      end
    endcase
  end

  assign emit_start = (seq_q == SEQ_PICK) && fld_present;
  assign rec_end    = ((seq_q == SEQ_PICK) && !fld_present && fld_q == FLD_LAST) ||
                      ((seq_q == SEQ_EMIT) && emit_done && fld_q == FLD_LAST);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      seq_q <= SEQ_IDLE;
      fld_q <= FLD_COUNT;
    end else begin
      case (seq_q)
        SEQ_IDLE: begin
          if (go) begin
            seq_q <= SEQ_PICK;
            fld_q <= FLD_COUNT;
          end
        end
        SEQ_PICK: begin
          if (fld_present) begin
            seq_q <= SEQ_EMIT;
          end else if (fld_q == FLD_LAST) begin
            seq_q <= SEQ_IDLE;
          end else begin
            fld_q <= fld_q + 4'h1;
          end
        end
        SEQ_EMIT: begin
          if (emit_done) begin
            if (fld_q == FLD_LAST) begin
              seq_q <= SEQ_IDLE;
            end else begin
              seq_q <= SEQ_PICK;
              fld_q <= fld_q + 4'h1;
            end
          end
        end
        default: begin
          seq_q <= SEQ_IDLE;
        end
      endcase
    end
  end

  iosf_emit u_emit (
    .clk       (sys_clk),
    .rst_n     (rst_n),
    .start     (emit_start),
    .value     (fld_value),
    .two_bytes (fld_two),
    .text_mode (text_q),
    .done      (emit_done),
    .out_data  (rec_data),
    .out_valid (rec_valid),
    .out_ready (rec_ready)
  );

  assign rec_busy = (seq_q != SEQ_IDLE);

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= '0;
    end else if (!reg_rd) begin
      rdata_q <= '0;
    end else if (reg_addr < ADDR_LINE_BASE + ADDR_W'(NUM_LINES)) begin
      rdata_q <= DATA_W'(func_q[4'(reg_addr - ADDR_LINE_BASE)]);
    end else begin
      case (reg_addr)
        ADDR_PULLUP: rdata_q <= DATA_W'(pullup_q);
        ADDR_CTRL:   rdata_q <= DATA_W'({text_q, 1'b0});
        ADDR_STATUS: rdata_q <= DATA_W'({done_q, rec_busy});
        ADDR_DMASK:  rdata_q <= DATA_W'(dmask_d);
        ADDR_AMASK:  rdata_q <= DATA_W'(amask_d);
        ADDR_DLEVEL: rdata_q <= DATA_W'(dio_s);
        default:     rdata_q <= '0;
      endcase
    end
  end

  assign reg_rdata = rdata_q;

endmodule

// File: bench/iosf_checker.sv
module iosf_checker
  import iosf_pkg::*;
#(
  parameter logic [12:0] ALT_MASK = ALT_LINES
) (
  // Clock and reset
  input wire logic                 sys_clk,
  input wire logic                 reset_n,
  // Pin controls
  input wire logic [NUM_LINES-1:0] dio_out,
  input wire logic [NUM_LINES-1:0] dio_oe,
  input wire logic [NUM_LINES-1:0] pullup_en,
  input wire logic [NUM_LINES-1:0] alt_sel,
  input wire logic [NUM_LINES-1:0] pwm_sel,
  // Record stream
  input wire logic [7:0]           rec_data,
  input wire logic                 rec_valid,
  input wire logic                 rec_ready,
  input wire logic                 rec_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dcb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  // Record opening: busy rises, count byte follows shortly
  sequence s_start;
    $rose(rec_busy);
  endsequence
  sequence s_count;
    rec_valid && (rec_data == SAMPLE_SETS || rec_data == CH_ZERO);
  endsequence

  a_count_first: assert property (s_start |-> ##[0:2] s_count)
    else $error("record does not open with the set count");
  a_stall_hold: assert property (rec_valid && !rec_ready |=> rec_valid && $stable(rec_data))
    else $error("record byte changed while stalled");
  a_valid_busy: assert property (rec_valid |-> rec_busy)
    else $error("record byte outside a record");
  a_out_driven: assert property ((dio_out & ~dio_oe) == '0)
    else $error("high level on an undriven line");
  a_oe_exclusive: assert property ((dio_oe & (alt_sel | pwm_sel)) == '0)
    else $error("line driven and used for another function");
  a_pwm_lines: assert property ((pwm_sel & ~PWM_LINES) == '0)
    else $error("pulse output on a line without one");
  a_alt_lines: assert property ((alt_sel & ~ALT_MASK) == '0)
    else $error("alternate function on a line without one");
  a_pull_inputs: assert property ((pullup_en & (dio_oe | alt_sel | pwm_sel)) == '0)
    else $error("pull-up on a line that is not an input");
endmodule

bind iosf_formatter iosf_checker #(.ALT_MASK(ALT_MASK)) i_iosf_checker (
  .sys_clk(sys_clk), .reset_n(reset_n), .dio_out(dio_out), .dio_oe(dio_oe),
  .pullup_en(pullup_en), .alt_sel(alt_sel), .pwm_sel(pwm_sel), .rec_data(rec_data),
  .rec_valid(rec_valid), .rec_ready(rec_ready), .rec_busy(rec_busy)
);

// File: bench/iosf_consumer.sv
module iosf_consumer (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Pace control
  input wire logic slow,
  // Record stream
  output logic     rec_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt_q;

  // Slow mode takes one byte in four, so stalls hit every field
  // content judged by the host, not here
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q     <= 2'h0;
      rec_ready <= 1'b0;
    end else begin
      cnt_q     <= cnt_q + 2'h1;
      rec_ready <= !slow || (cnt_q == 2'h3);
    end
  end
endmodule

// File: bench/tb_io_line_sample_formatter.sv
module tb_io_line_sample_formatter
  import iosf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [7:0] ln; logic [3:0] code; logic [3:0] rb; logic [4:0] sel;} iosf_row_s;

  logic                     sys_clk = 1'b0;
  logic                     reset_n = 1'b0;
  logic [ADDR_W-1:0]        reg_addr = '0;
  logic [DATA_W-1:0]        reg_wdata = '0;
  logic                     reg_wr = 1'b0;
  logic                     reg_rd = 1'b0;
  logic [DATA_W-1:0]        reg_rdata;
  logic [NUM_LINES-1:0]     dio_in, dio_out, dio_oe, pullup_en, alt_sel, pwm_sel, ext_lvl = 13'h1555;
  logic [NUM_AIN-1:0]       analog_sel;
  logic [12:0]              ana_ext;
  logic [NUM_AIN*ADC_W-1:0] adc_data = {10'h305, 10'h204, 10'h103, 10'h3FF, 10'h001, 10'h2AA};
  logic [7:0]               rec_data;
  logic                     rec_valid, rec_ready, rec_busy, slow = 1'b0;
  logic [7:0]               got_q[$], exp_q[$];
  int                       error_cnt = 0;
  int                       n_compared = 0;
  // Line, code, read-back, expected {oe, out, alt, pwm, analog}
  iosf_row_s rows[14] = '{'{2, 4, 4, 5'h10}, '{2, 5, 5, 5'h18}, '{2, 3, 3, 5'h00}, '{2, 0, 0, 5'h00},
    '{3, 2, 2, 5'h01}, '{10, 2, 2, 5'h02}, '{6, 7, 7, 5'h04}, '{1, 7, 0, 5'h00}, '{11, 1, 0, 5'h00},
    '{4, 12, 0, 5'h00}, '{7, 2, 0, 5'h00}, '{7, 6, 6, 5'h04}, '{8, 9, 9, 5'h04}, '{9, 8, 8, 5'h04}};

  // Clock, pin wire levels, record capture at the handshake edge
  always #2.5 sys_clk = ~sys_clk;
  assign dio_in  = (dio_oe & dio_out) | (~dio_oe & ext_lvl);
  assign ana_ext = {7'h0, analog_sel};
  always @(posedge sys_clk) if (rec_valid && rec_ready) got_q.push_back(rec_data);

  iosf_formatter i_iosf_formatter (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dio_in(dio_in),
    .dio_out(dio_out), .dio_oe(dio_oe), .pullup_en(pullup_en), .alt_sel(alt_sel), .pwm_sel(pwm_sel),
    .analog_sel(analog_sel), .adc_data(adc_data), .rec_data(rec_data), .rec_valid(rec_valid),
    .rec_ready(rec_ready), .rec_busy(rec_busy));
  iosf_consumer i_iosf_consumer (.sys_clk(sys_clk), .reset_n(reset_n), .slow(slow), .rec_ready(rec_ready));

  task automatic tally_and_finish;
    if (error_cnt == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Register bus: one strobe cycle, then an idle edge
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
    @(posedge sys_clk);
  endtask

  function automatic logic [7:0] hexc(input logic [3:0] d);
    return (d < 4'hA) ? CH_ZERO + {4'h0, d} : CH_A_OFS + {4'h0, d};
  endfunction

  // Expected field: binary high byte first, or text digits and CR
  task automatic put(input logic [15:0] v, input logic two, input logic txt);
    if (txt) begin
      exp_q.push_back(CH_ZERO);
      exp_q.push_back(CH_X);
      for (int i = (two ? 3 : 1); i >= 0; i--) exp_q.push_back(hexc(v[i*4+:4]));
      exp_q.push_back(CH_CR);
    end else begin
      if (two) exp_q.push_back(v[15:8]);
      exp_q.push_back(v[7:0]);
    end
  endtask

  task automatic run_rec(input logic txt, input logic [12:0] dm, input logic [5:0] am, input logic [12:0] st);
    int k;
    exp_q.delete();
    got_q.delete();
    put({8'h0, SAMPLE_SETS}, 1'b0, txt);
    put({3'h0, dm}, 1'b1, txt);
    put({10'h0, am}, 1'b0, txt);
    if (dm != '0) put({3'h0, st & dm}, 1'b1, txt);
    for (int c = 0; c < NUM_AIN; c++) if (am[c]) put({6'h0, adc_data[c*ADC_W+:ADC_W]}, 1'b1, txt);
    wr(ADDR_CTRL, {14'h0, txt, 1'b1});
    for (k = 0; k < 3000 && (rec_busy || k < 3); k++) @(posedge sys_clk);
    if (k == 3000) begin
      chk({15'h0, rec_busy}, 16'h0000);
      tally_and_finish();
    end
    repeat (2) @(posedge sys_clk);
    chk(16'(got_q.size()), 16'(exp_q.size()));
    foreach (exp_q[i]) if (i < got_q.size()) chk({8'h0, got_q[i]}, {8'h0, exp_q[i]});
  endtask

  initial begin
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    // Reset state
    chk({3'h0, alt_sel}, {3'h0, DEF_ALT_LINES});
    rd(ADDR_LINE_BASE + 8'h05, {12'h0, FN_ALT});
    chk({15'h0, rec_valid}, 16'h0000);
    // Per-line function table
    foreach (rows[i]) begin
      wr(ADDR_LINE_BASE + rows[i].ln, {12'h0, rows[i].code});
      repeat (3) @(posedge sys_clk);
      chk({11'h0, dio_oe[rows[i].ln], dio_out[rows[i].ln], alt_sel[rows[i].ln], pwm_sel[rows[i].ln],
           ana_ext[rows[i].ln]}, {11'h0, rows[i].sel});
      rd(ADDR_LINE_BASE + rows[i].ln, {12'h0, rows[i].rb});
    end
    chk({3'h0, alt_sel}, 16'h03E1);
    chk({3'h0, pwm_sel}, 16'h0400);
    rd(8'h3F, 16'h0000);
    wr(ADDR_LINE_BASE, {12'h0, FN_ANALOG});
    wr(ADDR_PULLUP, 16'h1FFF);
    repeat (3) @(posedge sys_clk);
    chk({3'h0, pullup_en}, 16'h1816);
    rd(ADDR_PULLUP, 16'h1FFF);
    // Binary record with a stalling host
    wr(ADDR_LINE_BASE + 8'h02, {12'h0, FN_DIN_MON});
    wr(ADDR_LINE_BASE + 8'h0A, {12'h0, FN_DOUT_LOW});
    wr(ADDR_LINE_BASE + 8'h0B, {12'h0, FN_DOUT_HIGH});
    repeat (4) @(posedge sys_clk);
    rd(ADDR_DMASK, 16'h0C04);
    rd(ADDR_AMASK, 16'h0009);
    slow <= 1'b1;
    run_rec(1'b0, 13'h0C04, 6'h09, 13'h0804);
    // Done flag sticks until written back
    rd(ADDR_STATUS, 16'h0002);
    wr(ADDR_STATUS, 16'h0002);
    rd(ADDR_STATUS, 16'h0000);
    // Text record, no digital lines, all channels
    slow <= 1'b0;
    for (int l = 1; l < 6; l++) wr(ADDR_LINE_BASE + 8'(l), {12'h0, FN_ANALOG});
    for (int l = 10; l < 12; l++) wr(ADDR_LINE_BASE + 8'(l), {12'h0, FN_DIN_QUIET});
    repeat (4) @(posedge sys_clk);
    run_rec(1'b1, 13'h0000, 6'h3F, 13'h0000);
    rd(ADDR_CTRL, 16'h0002);
    rd(ADDR_DLEVEL, 16'h1555);
    // Reset after the text record, while idle: settings fall back to defaults
    reset_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk({3'h0, alt_sel}, {3'h0, DEF_ALT_LINES});
    chk({3'h0, pullup_en | dio_oe | pwm_sel}, 16'h0000);
    chk({14'h0, rec_busy, rec_valid}, 16'h0000);
    rd(ADDR_LINE_BASE + 8'h0A, 16'h0000);
    rd(ADDR_STATUS, 16'h0000);
    tally_and_finish();
  end
endmodule
